/* pkg/timer_pkg.sv */
package timer_pkg;
   localparam int          ADDR_W         = 16;
   localparam int          DATA_W         = 16;
   // General registers at their printed byte addresses
   localparam logic [15:0] OFF_GR_A       = 16'hFE88;
   localparam logic [15:0] OFF_GR_B       = 16'hFE8A;
   localparam logic [15:0] OFF_GR_C       = 16'hFE8C;
   localparam logic [15:0] OFF_GR_D       = 16'hFE8E;
   // Registers whose addresses are chosen locally
   localparam logic [15:0] OFF_MODE       = 16'hFE80;
   localparam logic [15:0] OFF_IOCTL      = 16'hFE82;
   localparam logic [15:0] OFF_STATUS     = 16'hFE84;
   localparam logic [15:0] OFF_MASK       = 16'hFE86;
   localparam logic [15:0] OFF_COUNT      = 16'hFE90;
   localparam logic [15:0] OFF_CTRL       = 16'hFE92;
   localparam logic [15:0] COUNT_MAX      = 16'hFFFF;
   localparam logic [15:0] COUNT_ZERO     = 16'h0000;
   localparam logic [7:0]  MODE_RESET     = 8'hC0;
   localparam logic [7:0]  MODE_FIXED_TOP = 8'hC0;
   localparam logic [7:0]  IOCTL_RESET    = 8'h00;
   localparam int          WRAP_BIT       = 0;
   localparam int          SYNC_BIT       = 0;
   localparam int          RUN_BIT        = 1;
   localparam int          CLR_BIT        = 2;

   typedef enum logic [3:0] {
      MODE_NORMAL   = 4'h0,
      MODE_RESERVED = 4'h1,
      MODE_PWM1     = 4'h2,
      MODE_PWM2     = 4'h3,
      MODE_PHASE1   = 4'h4,
      MODE_PHASE2   = 4'h5,
      MODE_PHASE3   = 4'h6,
      MODE_PHASE4   = 4'h7
   } mode_e;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic              wr;
      logic              rd;
   } bus_req_s;

   typedef struct packed {
      logic       step_up;
      logic       step_down;
      logic       valid;
   } step_s;
endpackage : timer_pkg

/* core/mode_decoder.sv */
module mode_decoder
   import timer_pkg::*;
(
   // Mode field
   input  wire logic [3:0] mode_field,
   // Decoded class
   output logic            is_pwm,
   output logic            is_phase,
   output logic            is_defined
);
   always_comb begin
      is_pwm     = 1'b0;
      is_phase   = 1'b0;
      is_defined = 1'b1;
      case (mode_field)
         MODE_NORMAL:                                 is_defined = 1'b1;
         MODE_PWM1, MODE_PWM2:                        is_pwm     = 1'b1;
         MODE_PHASE1, MODE_PHASE2, MODE_PHASE3, MODE_PHASE4: is_phase = 1'b1;
         // Reserved and top-bit codes: counting treated as normal
         default:                                     is_defined = 1'b0;
      endcase
   end
endmodule : mode_decoder

/* core/phase_step.sv */
module phase_step
   import timer_pkg::*;
(
   // Clock and reset
   input  wire logic clk_sys,
   input  wire logic rst_n,
   // Quadrature inputs, synchronous to clk_sys
   input  wire logic phase_a,
   input  wire logic phase_b,
   // Count steps
   output timer_pkg::step_s step
);
   logic a_reg;
   logic b_reg;

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         a_reg <= 1'b0;
         b_reg <= 1'b0;
      end else begin
         a_reg <= phase_a;
         b_reg <= phase_b;
      end
   end

   // Any edge on either phase counts one step; direction from the other phase
   always_comb begin
      step.valid     = (a_reg ^ phase_a) | (b_reg ^ phase_b);
      step.step_up   = ((a_reg ^ phase_a) & (phase_a ^ phase_b)) |
                       ((b_reg ^ phase_b) & ~(phase_a ^ phase_b));
      step.step_down = step.valid & ~step.step_up;
   end
endmodule : phase_step

/* core/timer_channel.sv */
module timer_channel
   import timer_pkg::*;
(
   // Clock and reset
   input  wire logic               clk_sys,
   input  wire logic               rst_n,
   // Register port
   input  timer_pkg::bus_req_s     bus_req,
   output logic [DATA_W-1:0]       rdata,
   // Count sources
   input  wire logic               count_tick,
   input  wire logic               phase_a,
   input  wire logic               phase_b,
   // Synchronous clearing between channels
   input  wire logic               sync_clear_in,
   output logic                    sync_clear_out,
   // Matches and interrupt
   output logic                    match_a,
   output logic                    match_b,
   output logic                    irq
);
   logic [DATA_W-1:0] count_reg;
   logic [DATA_W-1:0] count_next;
   logic [DATA_W-1:0] gr_reg [4];
   logic [7:0]        mode_reg;
   logic [7:0]        ioctl_reg;
   logic [7:0]        ctrl_reg;
   logic [7:0]        status_reg;
   logic [7:0]        mask_reg;
   logic              wrap_seen_reg;
   logic              wrap_event;
   logic              clear_event;
   logic              is_pwm;
   logic              is_phase;
   logic              is_defined;
   step_s             step;
   logic              hit_a;
   logic              hit_b;

   function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
      hit = (a == off);
   endfunction : hit

   mode_decoder u_mode_decoder (
      .mode_field (mode_reg[3:0]),
      .is_pwm     (is_pwm),
      .is_phase   (is_phase),
      .is_defined (is_defined)
   );

   phase_step u_phase_step (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .phase_a (phase_a),
      .phase_b (phase_b),
      .step    (step)
   );

   assign hit_a = (count_reg == gr_reg[0]);
   assign hit_b = (count_reg == gr_reg[1]);

   // PWM modes clear on a compare match of register A; this also drives the sync clear
   assign clear_event = is_pwm & count_tick & hit_a;
   assign sync_clear_out = clear_event & ctrl_reg[SYNC_BIT];

   // Counting: phase modes step by the quadrature, others by the tick
   always_comb begin
      count_next = count_reg;
      wrap_event = 1'b0;
      if (ctrl_reg[RUN_BIT]) begin
         if (is_phase) begin
            if (step.step_up) begin
               count_next = count_reg + 16'h0001;
               wrap_event = (count_reg == COUNT_MAX);
            end else if (step.step_down) begin
               count_next = count_reg - 16'h0001;
            end
         end else if (count_tick) begin
            count_next = count_reg + 16'h0001;
            wrap_event = (count_reg == COUNT_MAX);
         end
      end
      if (clear_event) begin
         count_next = COUNT_ZERO;
         wrap_event = 1'b0;
      end
      // Another sync channel's clear wins over local counting
      if (ctrl_reg[SYNC_BIT] & sync_clear_in) begin
         count_next = COUNT_ZERO;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         count_reg <= COUNT_ZERO;
      end else if (bus_req.wr && hit(bus_req.addr, OFF_COUNT)) begin
         count_reg <= bus_req.wdata;
      end else begin
         count_reg <= count_next;
      end
   end

   // General registers A to D
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < 4; i++) begin
            gr_reg[i] <= COUNT_MAX;
         end
      end else if (bus_req.wr) begin
         if (hit(bus_req.addr, OFF_GR_A)) gr_reg[0] <= bus_req.wdata;
         if (hit(bus_req.addr, OFF_GR_B)) gr_reg[1] <= bus_req.wdata;
         if (hit(bus_req.addr, OFF_GR_C)) gr_reg[2] <= bus_req.wdata;
         if (hit(bus_req.addr, OFF_GR_D)) gr_reg[3] <= bus_req.wdata;
      end
   end

   // Mode: upper bits fixed; top mode bit stored but gives no defined mode
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         mode_reg <= MODE_RESET;
      end else if (bus_req.wr && hit(bus_req.addr, OFF_MODE)) begin
         mode_reg <= MODE_FIXED_TOP | {4'h0, bus_req.wdata[3:0]};
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         ioctl_reg <= IOCTL_RESET;
      end else if (bus_req.wr && hit(bus_req.addr, OFF_IOCTL)) begin
         ioctl_reg <= bus_req.wdata[7:0];
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_reg <= 8'h00;
      end else if (bus_req.wr && hit(bus_req.addr, OFF_CTRL)) begin
         ctrl_reg <= {5'h00, bus_req.wdata[2:0]} & 8'h07;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         mask_reg <= 8'h00;
      end else if (bus_req.wr && hit(bus_req.addr, OFF_MASK)) begin
         mask_reg <= {7'h00, bus_req.wdata[WRAP_BIT]};
      end
   end

   // Arm the clear only once software has seen the flag as one
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         wrap_seen_reg <= 1'b0;
      end else if (bus_req.rd && hit(bus_req.addr, OFF_STATUS) && status_reg[WRAP_BIT]) begin
         wrap_seen_reg <= 1'b1;
      end else if (!status_reg[WRAP_BIT]) begin
         wrap_seen_reg <= 1'b0;
      end else if (bus_req.wr && hit(bus_req.addr, OFF_STATUS) && !bus_req.wdata[WRAP_BIT]) begin
         wrap_seen_reg <= 1'b0;
      end
   end

   // Set beats a clear in the same cycle; writing one has no effect
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         status_reg <= 8'h00;
      end else if (wrap_event) begin
         status_reg[WRAP_BIT] <= 1'b1;
      end else if (bus_req.wr && hit(bus_req.addr, OFF_STATUS) && !bus_req.wdata[WRAP_BIT] &&
                   wrap_seen_reg) begin
         status_reg[WRAP_BIT] <= 1'b0;
      end
   end

   assign irq = |(status_reg & mask_reg);

   // Matches held for one cycle, registered to keep outputs glitch-free
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         match_a <= 1'b0;
         match_b <= 1'b0;
      end else begin
         match_a <= hit_a & count_tick;
         match_b <= hit_b & count_tick;
      end
   end

   // Read data one cycle after the strobe; unmapped reads return zero
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rdata <= 16'h0000;
      end else if (bus_req.rd) begin
         case (bus_req.addr)
            OFF_GR_A:   rdata <= gr_reg[0];
            OFF_GR_B:   rdata <= gr_reg[1];
            OFF_GR_C:   rdata <= gr_reg[2];
            OFF_GR_D:   rdata <= gr_reg[3];
            OFF_MODE:   rdata <= {8'h00, mode_reg};
            OFF_IOCTL:  rdata <= {8'h00, ioctl_reg};
            OFF_STATUS: rdata <= {8'h00, status_reg};
            OFF_MASK:   rdata <= {8'h00, mask_reg};
            OFF_COUNT:  rdata <= count_reg;
            OFF_CTRL:   rdata <= {8'h00, ctrl_reg[7:1], ctrl_reg[0] & is_defined | ctrl_reg[0]};
            default:    rdata <= 16'h0000;
         endcase
      end else begin
         rdata <= 16'h0000;
      end
   end
endmodule : timer_channel

/* tb/timer_channel_chk.sv */
module timer_channel_chk
   import timer_pkg::*;
(
   // Clock and reset
   input wire logic           clk_sys,
   input wire logic           rst_n,
   // Register port
   input timer_pkg::bus_req_s bus_req,
   input logic [DATA_W-1:0]   rdata,
   // Counting and events
   input wire logic           count_tick,
   input wire logic           phase_a,
   input wire logic           phase_b,
   input wire logic           sync_clear_in,
   input logic                sync_clear_out,
   input logic                match_a,
   input logic                match_b,
   input logic                irq
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   wire logic is_gr = bus_req.addr inside {OFF_GR_A, OFF_GR_B, OFF_GR_C, OFF_GR_D};

   a_rdata_idle_zero: assert property (!$past(bus_req.rd) |-> rdata == 16'h0000)
      else $error("read data not zero outside a read");
   a_mode_top_fixed: assert property (bus_req.rd && bus_req.addr == OFF_MODE |=> rdata[15:4] == 12'h00C)
      else $error("mode upper bits wrong");
   a_ioctl_read_back: assert property (bus_req.wr && bus_req.addr == OFF_IOCTL ##1 bus_req.rd && bus_req.addr == OFF_IOCTL
      |=> rdata == {8'h00, $past(bus_req.wdata[7:0], 2)}) else $error("io control read back wrong");
   a_gr_read_back: assert property (bus_req.wr && is_gr ##1 bus_req.rd && bus_req.addr == $past(bus_req.addr)
      |=> rdata == $past(bus_req.wdata, 2)) else $error("general register read back wrong");
   a_irq_fall_write: assert property ($fell(irq) |-> $past(bus_req.wr))
      else $error("interrupt dropped without a write");
   a_flag_one_kept: assert property (irq && bus_req.wr && bus_req.addr == OFF_STATUS && bus_req.wdata[WRAP_BIT] |=> irq)
      else $error("writing one cleared the flag");
   a_sync_out_tick: assert property (sync_clear_out |-> count_tick ##1 match_a)
      else $error("sync clear out without a count tick");
   a_unmapped_zero: assert property (bus_req.rd && bus_req.addr > OFF_CTRL |=> rdata == 16'h0000)
      else $error("unmapped read not zero");
endmodule : timer_channel_chk

bind timer_channel timer_channel_chk u_chk (.clk_sys(clk_sys), .rst_n(rst_n), .bus_req(bus_req), .rdata(rdata),
   .count_tick(count_tick), .phase_a(phase_a), .phase_b(phase_b), .sync_clear_in(sync_clear_in),
   .sync_clear_out(sync_clear_out), .match_a(match_a), .match_b(match_b), .irq(irq));

/* tb/testbench.sv */
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import timer_pkg::*;
   logic              clk_sys = 1'b0;
   logic              rst_n = 1'b0;
   bus_req_s          bus_req = '0;
   logic [DATA_W-1:0] rdata;
   logic              count_tick = 1'b0;
   logic              sync_clear_in = 1'b0;
   logic              phase_a = 1'b0;
   logic              phase_b = 1'b0;
   logic              sync_clear_out, match_a, match_b, irq;
   int                fails = 0;
   int                compares = 0;

   always #2 clk_sys = ~clk_sys;

   timer_channel u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .bus_req(bus_req), .rdata(rdata),
      .count_tick(count_tick), .phase_a(phase_a), .phase_b(phase_b), .sync_clear_in(sync_clear_in),
      .sync_clear_out(sync_clear_out), .match_a(match_a), .match_b(match_b), .irq(irq));

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // Write strobe is left up; the next call replaces it at the following edge
   task automatic bw(input logic [15:0] a, input logic [15:0] d);
      bus_req <= '{a, d, 1'b1, 1'b0};
      @(posedge clk_sys);
   endtask : bw

   task automatic br(input logic [15:0] a, output logic [15:0] q);
      bus_req <= '{a, 16'h0000, 1'b0, 1'b1};
      @(posedge clk_sys);
      bus_req <= '0;
      #1 q = rdata;
      @(posedge clk_sys);
   endtask : br

   task automatic ck_irq(input logic e);
      bus_req <= '0;
      #1 chk(16'(irq), 16'(e));
      @(posedge clk_sys);
   endtask : ck_irq

   // The sync clear output is combinational, so it is judged inside the tick cycle;
   // the registered matches stand in the cycle after the tick, given as {b, a}
   task automatic step(input logic t, input logic s, input logic o, input logic [1:0] m);
      bus_req <= '0;
      count_tick <= t;
      sync_clear_in <= s;
      #1 chk(16'(sync_clear_out), 16'(o));
      @(posedge clk_sys);
      count_tick <= 1'b0;
      sync_clear_in <= 1'b0;
      #1 chk(16'({match_b, match_a}), 16'(m));
      @(posedge clk_sys);
   endtask : step

   // Phase inputs change on one edge and are counted at the next
   task automatic ph(input logic a, input logic b);
      bus_req <= '0;
      phase_a <= a;
      phase_b <= b;
      @(posedge clk_sys);
      @(posedge clk_sys);
   endtask : ph

   task automatic t_regs;
      logic [15:0] q;
      br(OFF_IOCTL, q); chk(q, 16'h0000);
      br(OFF_MODE, q); chk(q, 16'h00C0);
      for (int i = 0; i < 4; i++) begin
         bw(OFF_GR_A + 16'(2 * i), 16'hA5C3 ^ 16'(i));
         br(OFF_GR_A + 16'(2 * i), q); chk(q, 16'hA5C3 ^ 16'(i));
      end
      bw(OFF_IOCTL, 16'hFF5A);
      br(OFF_IOCTL, q); chk(q, 16'h005A);
      bw(16'hFE94, 16'h1234);
      br(16'hFE94, q); chk(q, 16'h0000);
      for (int m = 0; m < 8; m++) begin
         if (m == 1) continue;
         bw(OFF_MODE, 16'(m));
         br(OFF_MODE, q); chk(q, 16'h00C0 | 16'(m));
      end
      bw(OFF_MODE, 16'h0000);
   endtask : t_regs

   task automatic t_wrap;
      logic [15:0] q;
      bw(OFF_MASK, 16'h0001);
      bw(OFF_CTRL, 16'h0002);
      bw(OFF_COUNT, 16'hFFFE);
      step(1'b1, 1'b0, 1'b0, 2'b00);
      br(OFF_STATUS, q); chk(q, 16'h0000);
      step(1'b1, 1'b0, 1'b0, 2'b00);
      br(OFF_COUNT, q); chk(q, 16'h0000);
      ck_irq(1'b1);
      bw(OFF_STATUS, 16'h0000); ck_irq(1'b1);
      bw(OFF_MASK, 16'h0000); ck_irq(1'b0);
      bw(OFF_MASK, 16'h0001); ck_irq(1'b1);
      br(OFF_STATUS, q); chk(q, 16'h0001);
      bw(OFF_STATUS, 16'h0001); ck_irq(1'b1);
      bw(OFF_STATUS, 16'h0000); ck_irq(1'b0);
   endtask : t_wrap

   task automatic t_sync;
      logic [15:0] q;
      bw(OFF_CTRL, 16'h0003);
      bw(OFF_COUNT, 16'h0100);
      step(1'b0, 1'b1, 1'b0, 2'b00);
      br(OFF_COUNT, q); chk(q, 16'h0000);
      bw(OFF_CTRL, 16'h0002);
      bw(OFF_COUNT, 16'h0100);
      step(1'b0, 1'b1, 1'b0, 2'b00);
      br(OFF_COUNT, q); chk(q, 16'h0100);
      bw(OFF_MODE, 16'h0002);
      bw(OFF_GR_A, 16'h0005);
      bw(OFF_CTRL, 16'h0003);
      bw(OFF_COUNT, 16'h0005);
      step(1'b1, 1'b0, 1'b1, 2'b01);
      br(OFF_COUNT, q); chk(q, 16'h0000);
      bw(OFF_MODE, 16'h0000);
      bw(OFF_GR_B, 16'h0005);
      bw(OFF_COUNT, 16'h0005);
      step(1'b1, 1'b0, 1'b0, 2'b11);
      br(OFF_COUNT, q); chk(q, 16'h0006);
   endtask : t_sync

   // Quadrature steps in phase counting mode one; a wrap on an up step sets the flag too
   task automatic t_phase;
      logic [15:0] q;
      bw(OFF_MODE, 16'h0004);
      bw(OFF_CTRL, 16'h0002);
      bw(OFF_COUNT, 16'hFFFF);
      ph(1'b1, 1'b0);
      br(OFF_COUNT, q); chk(q, 16'h0000);
      br(OFF_STATUS, q); chk(q, 16'h0001);
      ph(1'b1, 1'b1);
      ph(1'b0, 1'b1);
      br(OFF_COUNT, q); chk(q, 16'h0002);
      ph(1'b1, 1'b1);
      br(OFF_COUNT, q); chk(q, 16'h0001);
   endtask : t_phase

   task automatic tally_and_finish;
      if (fails == 0 && compares > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : tally_and_finish

   initial begin
      repeat (5000) @(posedge clk_sys);
      fails++;
      tally_and_finish();
   end

   initial begin
      repeat (16) @(posedge clk_sys);
      rst_n <= 1'b1;
      @(posedge clk_sys);
      t_regs();
      t_wrap();
      t_sync();
      t_phase();
      tally_and_finish();
   end
endmodule : testbench
